//--- rtl/exec_pkg.sv
// constants, field layouts and state types for the skip/indexed execute block
// assumes one 10 MHz clock; one instruction cycle spans four clocks (q1..q4)
// Operation
// RULE1: opcode 1011 tests bit, skips when clear
// RULE2: opcode 1010 tests bit, skips when set
// RULE3: taken skip discards prefetch, runs one nop
// RULE4: skip over two-word instruction flushes both
// RULE5: access bit zero fixed bank, one banked
// RULE6: extended set, a=0, f<=95 uses frame offset
// RULE7: two-word indexed move, frame plus 7-bit offsets
// RULE8: move addresses reach full 4096-byte space
// RULE9: fetch never moves into pc/stack-top bytes; not enforced, the move writes any address outside the indirect window
// RULE10: indirect source register reads as zero
// RULE11: indirect destination register suppresses write
// RULE12: move reads at q4, writes next q4
// RULE13: push writes literal at frame pointer, q4
// RULE14: push then decrements 12-bit frame pointer
// RULE15: status flags untouched; bit test phase plan
package exec_pkg;
   // ----------------------------------------------------------------
   // opcodes and field positions
   // ----------------------------------------------------------------
   localparam logic [3:0]  OP_BT_CLEAR    = 4'hb;   // upper nibble, skip if clear
   localparam logic [3:0]  OP_BT_SET      = 4'ha;   // upper nibble, skip if set
   localparam logic [7:0]  OP_MOVE_W1     = 8'heb;  // first word of indexed move
   localparam logic [3:0]  OP_MOVE_W2     = 4'hf;   // second word prefix
   localparam logic [7:0]  OP_PUSH_LIT    = 8'hea;  // push literal
   localparam int          BIT_IDX_LSB    = 9;      // bit index sits in [11:9]
   localparam int          ACCESS_BIT     = 8;      // access-select bit
   localparam int          OFFSET_W       = 7;      // indexed offset width
   // ----------------------------------------------------------------
   // address map
   // ----------------------------------------------------------------
   localparam logic [7:0]  LIT_OFFSET_MAX = 8'h5f;  // highest literal offset
   localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;  // low/high half of access bank
   localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;
   localparam logic [11:0] INDIRECT_LO    = 12'hfd8; // indirect register window
   localparam logic [11:0] INDIRECT_HI    = 12'hfef;
   localparam logic [11:0] FP_RESET       = 12'h000; // frame pointer after reset
   localparam logic [11:0] FP_STEP        = 12'h001; // push decrement
   localparam logic [1:0]  FLUSH_ONE      = 2'h1;    // nop cycles after a skip
   localparam logic [1:0]  FLUSH_TWO      = 2'h2;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
   typedef enum logic [1:0] {ST_RUN, ST_MOVE_DST, ST_FLUSH} exec_state_t;
endpackage

//--- rtl/quad_phase.sv
// four-phase instruction cycle generator
// assumes the core clock is the only clock; phases advance every clock
module quad_phase
   import exec_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst_n,
   output phase_t    phase
);
   // ----------------------------------------------------------------
   // phase counter
   // ----------------------------------------------------------------
   // q1 after reset so the first fetch boundary lands four clocks in
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= PH_Q1;
      end else begin
         unique case (phase)
            PH_Q1: phase <= PH_Q2;
            PH_Q2: phase <= PH_Q3;
            PH_Q3: phase <= PH_Q4;
            PH_Q4: phase <= PH_Q1;
         endcase
      end
   end
endmodule

//--- rtl/bit_skip_indexed_move_exec.sv
// execute stage for bit-test skips, indexed move and push literal
// assumes fetch presents the next word and its two-word flag at the end of q4,
// and data memory answers a read within the clock that mem_rd is high
module bit_skip_indexed_move_exec
   import exec_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [15:0] instr_word,      // word prefetched this cycle
   input  wire logic        instr_valid,     // that word is real
   input  wire logic        next_two_word,   // that word opens a two-word instruction
   input  wire logic        ext_set_en,      // extended instruction set enabled
   input  wire logic [3:0]  bank_select_reg, // current bank
   input  wire logic        fp_wr,           // core loads the frame pointer
   input  wire logic [11:0] fp_wdata,
   input  wire logic [7:0]  mem_rdata,
   output logic      [11:0] mem_addr,
   output logic             mem_rd,
   output logic             mem_wr,
   output logic      [7:0]  mem_wdata,
   output logic      [11:0] frame_pointer,
   output logic             nop_cycle,       // flushed instruction cycle
   output phase_t           phase
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   exec_state_t  state;          // sequencing state
   logic [15:0]  ir;             // word executing this cycle
   logic         ir_valid;       // zero means a nop cycle
   logic [1:0]   flush_left;     // nop cycles still owed, current included
   logic         test_bit;       // bit sampled in q2
   logic         skip_pending;   // skip decision from q3
   logic [7:0]   move_data;      // byte carried between move cycles
   logic         dst_nop;        // move write dropped, helper for checks
   logic [11:0]  bt_addr;        // bit-test operand address
   logic [11:0]  src_addr;
   logic [11:0]  dst_addr;
   logic         is_btc;
   logic         is_bts;
   logic         is_move1;
   logic         is_push;

   quad_phase u_phase (
      .mclk  (mclk),
      .rst_n (rst_n),
      .phase (phase)
   );

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // window of registers that stand for indirect access
   function automatic logic is_ind(input logic [11:0] a);
      is_ind = (a >= INDIRECT_LO) && (a <= INDIRECT_HI);
   endfunction

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   // RULE1 skip-if-clear pattern
   assign is_btc   = ir_valid && (state == ST_RUN) && (ir[15:12] == OP_BT_CLEAR);
   // RULE2 skip-if-set pattern
   assign is_bts   = ir_valid && (state == ST_RUN) && (ir[15:12] == OP_BT_SET);
   // RULE7 first word of the move
   assign is_move1 = ir_valid && (state == ST_RUN) && (ir[15:8] == OP_MOVE_W1);
   // RULE13 push literal pattern
   assign is_push  = ir_valid && (state == ST_RUN) && (ir[15:8] == OP_PUSH_LIT);

   // ----------------------------------------------------------------
   // address formation
   // ----------------------------------------------------------------
   // bit-test operand: banked, literal offset, or fixed access bank
   always_comb begin
      if (ir[ACCESS_BIT]) begin
         // RULE5 banked access by default
         bt_addr = {bank_select_reg, ir[7:0]};
      end else if (ext_set_en && (ir[7:0] <= LIT_OFFSET_MAX)) begin
         // RULE6 literal offset from frame pointer
         bt_addr = frame_pointer + {4'h0, ir[7:0]};
      end else if (ir[7:0] < ACCESS_SPLIT) begin
         // RULE5 fixed access bank, low half
         bt_addr = {ACCESS_LO_BANK, ir[7:0]};
      end else begin
         bt_addr = {ACCESS_HI_BANK, ir[7:0]};
      end
   end

   // RULE8 full 12-bit sum, no bank clipping
   assign src_addr = frame_pointer + {5'h00, ir[OFFSET_W-1:0]};
   assign dst_addr = frame_pointer + {5'h00, ir[OFFSET_W-1:0]};

   // ----------------------------------------------------------------
   // cycle sequencing and instruction register
   // ----------------------------------------------------------------
   // all transitions happen on the q4 edge, the fetch boundary
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state      <= ST_RUN;
         ir         <= 16'h0000;
         ir_valid   <= 1'b0;
         flush_left <= 2'h0;
         nop_cycle  <= 1'b0;
      end else if (phase == PH_Q4) begin
         unique case (state)
            ST_RUN: begin
               ir <= instr_word;
               if ((is_btc || is_bts) && skip_pending) begin
                  // RULE3 discard prefetched word, nop in its place
                  ir_valid   <= 1'b0;
                  nop_cycle  <= 1'b1;
                  state      <= ST_FLUSH;
                  // RULE4 two-word target costs a second nop
                  flush_left <= next_two_word ? FLUSH_TWO : FLUSH_ONE;
               end else if (is_move1) begin
                  // RULE12 second word drives the destination cycle
                  ir_valid <= instr_valid;
                  state    <= ST_MOVE_DST;
               end else begin
                  ir_valid <= instr_valid;
               end
            end
            ST_MOVE_DST: begin
               ir       <= instr_word;
               ir_valid <= instr_valid;
               state    <= ST_RUN;
            end
            ST_FLUSH: begin
               ir <= instr_word;
               if (flush_left == FLUSH_TWO) begin
                  // RULE4 second word is dropped as well
                  flush_left <= FLUSH_ONE;
                  ir_valid   <= 1'b0;
               end else begin
                  flush_left <= 2'h0;
                  nop_cycle  <= 1'b0;
                  ir_valid   <= instr_valid;
                  state      <= ST_RUN;
               end
            end
            default: begin
               state    <= ST_RUN;
               ir_valid <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // data memory port
   // ----------------------------------------------------------------
   // strobes last one clock; rd in q2 for bit tests, q4 for the move
   // source, wr in q4. nothing here drives the alu flags.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mem_addr  <= 12'h000;
         mem_rd    <= 1'b0;
         mem_wr    <= 1'b0;
         mem_wdata <= 8'h00;
         dst_nop   <= 1'b0;
      end else begin
         mem_rd  <= 1'b0;
         mem_wr  <= 1'b0;
         dst_nop <= 1'b0;
         if (phase == PH_Q1 && (is_btc || is_bts)) begin
            // RULE15 read register in q2
            mem_addr <= bt_addr;
            mem_rd   <= 1'b1;
         end else if (phase == PH_Q3 && is_move1) begin
            // RULE10 indirect source is never touched in memory
            mem_addr <= src_addr;
            mem_rd   <= !is_ind(src_addr);
         end else if (phase == PH_Q3 && state == ST_MOVE_DST) begin
            mem_addr  <= dst_addr;
            mem_wdata <= move_data;
            // RULE11 indirect destination turns the move into a nop
            mem_wr    <= !is_ind(dst_addr);
            dst_nop   <= is_ind(dst_addr);
         end else if (phase == PH_Q3 && is_push) begin
            // RULE13 literal to current frame pointer in q4
            mem_addr  <= frame_pointer;
            mem_wdata <= ir[7:0];
            mem_wr    <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // bit test evaluation
   // ----------------------------------------------------------------
   // q2 edge captures the bit, q3 edge decides, q4 is idle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         test_bit     <= 1'b0;
         skip_pending <= 1'b0;
      end else if (phase == PH_Q2 && mem_rd) begin
         test_bit <= mem_rdata[ir[BIT_IDX_LSB +: 3]];
      end else if (phase == PH_Q3) begin
         // RULE1 clear bit skips; RULE2 set bit skips
         skip_pending <= (is_btc && !test_bit) || (is_bts && test_bit);
      end
   end

   // ----------------------------------------------------------------
   // move source capture
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         move_data <= 8'h00;
      end else if (phase == PH_Q4 && is_move1) begin
         // RULE10 indirect source reads as zero
         move_data <= mem_rd ? mem_rdata : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // frame pointer
   // ----------------------------------------------------------------
   // a core load wins over the push decrement in the same clock
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         frame_pointer <= FP_RESET;
      end else if (fp_wr) begin
         frame_pointer <= fp_wdata;
      end else if (phase == PH_Q4 && is_push) begin
         // RULE14 12-bit decrement after the write
         frame_pointer <= frame_pointer - FP_STEP;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_rd_phase_slot:  assert property (mem_rd |-> (phase == PH_Q2 || phase == PH_Q4)) // RULE15
      else $error("read strobe outside q2 or q4");
   a_wr_phase_slot:  assert property (mem_wr |-> phase == PH_Q4) // RULE12
      else $error("write strobe outside q4");
   a_push_write:     assert property ((phase == PH_Q4 && is_push) |->
                        (mem_wr && mem_addr == frame_pointer && mem_wdata == ir[7:0])) // RULE13
      else $error("push literal write wrong");
   a_fp_decrement:   assert property ((phase == PH_Q4 && is_push && !fp_wr) |=>
                        frame_pointer == $past(frame_pointer) - FP_STEP) // RULE14
      else $error("frame pointer not decremented");
   a_skip_one_nop:   assert property ((phase == PH_Q4 && is_bts && skip_pending && !next_two_word)
                        |=> nop_cycle [*4] ##1 !nop_cycle) // RULE3
      else $error("single skip nop length wrong");
   a_skip_two_nop:   assert property ((phase == PH_Q4 && is_btc && skip_pending && next_two_word)
                        |=> nop_cycle [*8] ##1 !nop_cycle) // RULE4
      else $error("double skip nop length wrong");
   a_clear_decides:  assert property ((phase == PH_Q3 && is_btc) |=>
                        skip_pending == !$past(test_bit)) // RULE1
      else $error("skip-if-clear decision wrong");
   a_set_decides:    assert property ((phase == PH_Q3 && is_bts) |=>
                        skip_pending == $past(test_bit)) // RULE2
      else $error("skip-if-set decision wrong");
   a_banked_addr:    assert property ((phase == PH_Q1 && (is_btc || is_bts) && ir[ACCESS_BIT])
                        |=> mem_addr == {$past(bank_select_reg), $past(ir[7:0])}) // RULE5
      else $error("banked operand address wrong");
   a_src_indirect:   assert property ((phase == PH_Q4 && is_move1 && !mem_rd) |=>
                        move_data == 8'h00) // RULE10
      else $error("indirect source not zero");
   a_move_dst_slot:  assert property ((phase == PH_Q4 && is_move1) |-> ##4
                        ((mem_wr && !is_ind(mem_addr)) || dst_nop)) // RULE11
      else $error("move destination cycle wrong");
endmodule

//--- testbench/data_mem_model.sv
// data memory partner for the execute block: 4096 bytes, single port
// assumes reads are answered inside the clock where mem_rd is high
module data_mem_model
(
   input  wire logic        mclk,
   input  wire logic [11:0] mem_addr,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   input  wire logic [7:0]  mem_wdata,
   output logic      [7:0]  mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [7:0] mem [0:4095];  // bench preloads and inspects this
   logic [7:0] last_rd;       // last byte handed out

   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'h00;
      end
      last_rd = 8'h00;
   end

   // read data only while selected; inverted otherwise so stale data never passes
   assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_rd;

   // remember the answer, take writes on the clock edge
   always @(posedge mclk) begin
      if (mem_rd) begin
         last_rd <= mem[mem_addr];
      end
      if (mem_wr) begin
         mem[mem_addr] <= mem_wdata;
      end
   end
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the skip / indexed move / push execute block
// assumes one 10 MHz clock and the memory partner in data_mem_model
module tb_top
   import exec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk, rst_n, instr_valid, next_two_word, ext_set_en, fp_wr;
   logic [15:0] instr_word;
   logic [3:0]  bank_select_reg;
   logic [11:0] fp_wdata, mem_addr, frame_pointer;
   logic [7:0]  mem_rdata, mem_wdata;
   logic        mem_rd, mem_wr, nop_cycle;
   phase_t      phase;
   int          mismatches, compares, nop_clocks;

   bit_skip_indexed_move_exec bit_skip_indexed_move_exec_i (.mclk(mclk), .rst_n(rst_n),
      .instr_word(instr_word), .instr_valid(instr_valid), .next_two_word(next_two_word),
      .ext_set_en(ext_set_en), .bank_select_reg(bank_select_reg), .fp_wr(fp_wr),
      .fp_wdata(fp_wdata), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .frame_pointer(frame_pointer),
      .nop_cycle(nop_cycle), .phase(phase));
   data_mem_model data_mem_model_i (.mclk(mclk), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   // ----------------------------------------------------------------
   // clock, nop counter, watchdog
   // ----------------------------------------------------------------
   always #50 mclk = ~mclk;
   // counts flushed clocks mid-clock, where nop_cycle has settled
   always @(negedge mclk) if (nop_cycle === 1'b1) nop_clocks++;
   // all tests need well under 2000 clocks
   initial begin
      repeat (5000) @(posedge mclk);
      mismatches++;
      end_of_test();
   end

   // ----------------------------------------------------------------
   // compare and drive tasks
   // ----------------------------------------------------------------
   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_addr(input string what, input logic [11:0] exp, input logic [11:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_count(input string what, input int exp, input int got);
      compares++;
      if (got != exp) begin
         mismatches++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   // present a word so that the next q4 edge takes it; phase is read mid-clock
   task automatic issue(input logic [15:0] w, input logic v, input logic two);
      @(negedge mclk);
      while (phase !== PH_Q3) @(negedge mclk);
      @(posedge mclk);
      instr_word <= w;
      instr_valid <= v;
      next_two_word <= two;
   endtask
   task automatic run_idle(input int n);
      repeat (n) issue(16'h0000, 1'b0, 1'b0);
   endtask
   // load only between instructions; the load would beat a push decrement
   task automatic load_fp(input logic [11:0] v);
      @(posedge mclk);
      fp_wr <= 1'b1;
      fp_wdata <= v;
      @(posedge mclk);
      fp_wr <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // bit test; the prefetched word (or pair) is a plain nop word
   task automatic bit_test(input logic [3:0] op, input logic [2:0] b, input logic a,
      input logic [7:0] f, input logic ext, input logic [11:0] addr, input logic bv,
      input logic two);
      int exp_nop;
      exp_nop = ((op == OP_BT_SET) == bv) ? (two ? 8 : 4) : 0;
      data_mem_model_i.mem[addr] = bv ? (8'h01 << b) : ~(8'h01 << b);
      ext_set_en <= ext;
      issue({op, b, a, f}, 1'b1, 1'b0);
      nop_clocks = 0;
      issue(16'h0000, 1'b1, two);
      run_idle(3);
      chk_addr("bit test address", addr, mem_addr);
      chk_count("flushed clocks", exp_nop, nop_clocks);
      $display("test bit_test done");
   endtask
   // indexed move; destinations are kept off pc-low and stack-top bytes
   task automatic move(input logic [11:0] fp, input logic [6:0] zs, input logic [6:0] zd,
      input logic [7:0] src, input logic [7:0] exp);
      load_fp(fp);
      data_mem_model_i.mem[fp + zs] = src;
      data_mem_model_i.mem[fp + zd] = 8'hc3;
      issue({OP_MOVE_W1, 1'b1, zs}, 1'b1, 1'b1);
      issue({OP_MOVE_W2, 5'h00, zd}, 1'b1, 1'b0);
      run_idle(2);
      chk_byte("move destination", exp, data_mem_model_i.mem[fp + zd]);
      chk_addr("frame pointer after move", fp, frame_pointer);
      $display("test move done");
   endtask
   // two pushes back to back
   task automatic push(input logic [11:0] fp, input logic [7:0] k);
      load_fp(fp);
      issue({OP_PUSH_LIT, k}, 1'b1, 1'b0);
      issue({OP_PUSH_LIT, ~k}, 1'b1, 1'b0);
      run_idle(2);
      chk_byte("first push", k, data_mem_model_i.mem[fp]);
      chk_byte("second push", ~k, data_mem_model_i.mem[fp - 12'h001]);
      chk_addr("frame pointer after push", fp - 12'h002, frame_pointer);
      $display("test push done");
   endtask

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      {instr_valid, next_two_word, ext_set_en, fp_wr} = 4'h0;
      instr_word = 16'h0000;
      bank_select_reg = 4'h3;
      fp_wdata = 12'h000;
      mismatches = 0;
      compares = 0;
      nop_clocks = 0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      load_fp(12'h200);
      bit_test(OP_BT_CLEAR, 3'h1, 1'b1, 8'h44, 1'b0, 12'h344, 1'b0, 1'b0);
      bit_test(OP_BT_CLEAR, 3'h7, 1'b1, 8'h44, 1'b0, 12'h344, 1'b1, 1'b1);
      bit_test(OP_BT_SET, 3'h0, 1'b0, 8'h20, 1'b0, 12'h020, 1'b1, 1'b1);
      bit_test(OP_BT_SET, 3'h6, 1'b0, 8'h80, 1'b0, 12'hf80, 1'b0, 1'b0);
      bit_test(OP_BT_SET, 3'h2, 1'b0, 8'h5f, 1'b1, 12'h25f, 1'b1, 1'b0);
      bit_test(OP_BT_CLEAR, 3'h5, 1'b0, 8'h60, 1'b1, 12'hf60, 1'b0, 1'b1);
      move(12'h080, 7'h05, 7'h06, 8'h33, 8'h33);
      move(12'hf80, 7'h7f, 7'h00, 8'h9e, 8'h9e);
      move(12'hfd0, 7'h08, 7'h02, 8'h77, 8'h00);
      move(12'hfd0, 7'h02, 7'h10, 8'h44, 8'hc3);
      push(12'h1ec, 8'h08);
      push(12'h100, 8'h5a);
      push(12'h000, 8'hff);
      end_of_test();
   end
endmodule
